/* pkg/swb_pkg.sv */
// Purpose: Shared constants and carriers for the subtract-with-borrow execution block.
// Assumes: One instruction cycle of four core clock phases.
// Notes: The APB register map is listed here too.
//
// What this block does
// RULE1 - Result is file value minus accumulator minus inverted carry, two's complement.
// RULE2 - Destination bit zero writes the result into the accumulator only.
// RULE3 - Destination bit one writes the result back into the file register.
// RULE4 - Bank-select zero resolves the address inside the fixed access bank.
// RULE5 - Bank-select one joins the bank pointer with the address field.
// RULE6 - Extended set, bank-select zero, address up to 5Fh: indexed literal offset.
// RULE7 - Decode 0101 10da opcode, one four-phase cycle, update N OV C DC Z.
package swb_pkg;

	// ----------------------------------------
	// Opcode layout
	// ----------------------------------------
	localparam logic [5:0] SWB_OPCODE = 6'h16;
	localparam int SWB_OP_HI = 15;
	localparam int SWB_OP_LO = 10;
	localparam int SWB_D_BIT = 9;
	localparam int SWB_A_BIT = 8;
	localparam logic [7:0] SWB_ILO_LIMIT = 8'h5F;
	localparam logic [3:0] SWB_ACCESS_HI_BANK = 4'hF;
	localparam logic [7:0] SWB_ACCESS_SPLIT = 8'h60;

	// ----------------------------------------
	// Register map, byte addresses
	// ----------------------------------------
	localparam logic [7:0] SWB_OFS_INSTR = 8'h00;
	localparam logic [7:0] SWB_OFS_ACC = 8'h04;
	localparam logic [7:0] SWB_OFS_STATUS = 8'h08;
	localparam logic [7:0] SWB_OFS_BANK = 8'h0C;
	localparam logic [7:0] SWB_OFS_INDEX = 8'h10;
	localparam logic [7:0] SWB_OFS_CTRL = 8'h14;
	localparam logic [7:0] SWB_OFS_FADDR = 8'h18;
	localparam logic [7:0] SWB_OFS_FDATA = 8'h1C;

	// ----------------------------------------
	// Reset values and flag positions
	// ----------------------------------------
	localparam logic [7:0] SWB_ACC_RST = 8'h00;
	localparam logic [4:0] SWB_FLAGS_RST = 5'h00;
	localparam int SWB_FC = 0;
	localparam int SWB_FDC = 1;
	localparam int SWB_FZ = 2;
	localparam int SWB_FOV = 3;
	localparam int SWB_FN = 4;
	localparam int SWB_PHASES = 4;

	// Phases of one instruction cycle.
	typedef enum logic [1:0] {SWB_DECODE, SWB_READ, SWB_PROCESS, SWB_WRITE} swb_phase_e;

	// Result of the arithmetic unit.
	typedef struct packed {
		logic [7:0] value;
		logic [4:0] flags;
	} swb_result_s;

endpackage

/* src/swb_alu.sv */
// Purpose: Combinational subtract-with-borrow arithmetic and flag generation.
// Assumes: Carry set means no borrow.
// Notes: Pure logic, no state.
`timescale 1ns/1ns
module swb_alu
	import swb_pkg::*;
(
	// Operands
	input wire logic [7:0] file_val,
	input wire logic [7:0] acc_val,
	input wire logic carry_in,
	// Result
	output swb_result_s res
);

	logic [8:0] full;
	logic [4:0] low;
	logic [7:0] diff;

	// Adding the inverted accumulator plus carry equals f - W - !C, and the ninth bit
	// is then the no-borrow carry.
	always_comb
	begin
		full = {1'b0, file_val} + {1'b0, ~acc_val} + {8'h00, carry_in}; // [RULE1]
		low = {1'b0, file_val[3:0]} + {1'b0, ~acc_val[3:0]} + {4'h0, carry_in};
		diff = full[7:0];
		res.value = diff;
		res.flags[SWB_FC] = full[8]; // [RULE7]
		res.flags[SWB_FDC] = low[4];
		res.flags[SWB_FZ] = (diff == 8'h00);
		res.flags[SWB_FOV] = (file_val[7] != acc_val[7]) && (diff[7] != file_val[7]);
		res.flags[SWB_FN] = diff[7];
	end

endmodule

/* src/swb_exec.sv */
// Purpose: Executes the subtract-with-borrow instruction over four phases.
// Assumes: APB slave, one clock, file register space held here as flip-flops.
// Notes: Writing the subtract-with-borrow opcode to the instruction register while idle starts one instruction cycle.
`timescale 1ns/1ns
module swb_exec
	import swb_pkg::*;
#(
	parameter int FILE_WORDS = 256
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Status
	output logic busy,
	output logic illegal_op
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [15:0] instr_r;
	logic [7:0] acc_r;
	logic [4:0] flags_r;
	logic [3:0] bank_pointer_r;
	logic [11:0] index_r;
	logic ext_set_r;
	logic [7:0] faddr_r;
	logic [7:0] file_r [FILE_WORDS];
	logic [7:0] fval_r;
	logic [7:0] eff_addr_r;
	logic [11:0] full_addr_r;
	logic start_r;
	swb_phase_e phase_r;
	swb_result_s res_r;
	swb_result_s res;

	logic apb_wr;
	logic apb_rd;
	logic mapped;

	// Full 12-bit data address with bank and indexed modes resolved.
	function automatic logic [11:0] resolve(input logic [15:0] ins, input logic [3:0] bank,
		input logic [11:0] idx, input logic ext);
		logic [7:0] f;
		f = ins[7:0];
		if (ins[SWB_A_BIT])
			resolve = {bank, f}; // [RULE5]
		else if (ext && f <= SWB_ILO_LIMIT)
			resolve = idx + {4'h0, f}; // [RULE6]
		else if (f >= SWB_ACCESS_SPLIT)
			resolve = {SWB_ACCESS_HI_BANK, f}; // [RULE4]
		else
			resolve = {4'h0, f};
	endfunction

	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && !penable && !pwrite;
	assign mapped = paddr <= SWB_OFS_FDATA && paddr[1:0] == 2'b00;

	swb_alu u_alu
	(
		.file_val(fval_r),
		.acc_val(acc_r),
		.carry_in(flags_r[SWB_FC]),
		.res(res)
	);

	// ----------------------------------------
	// APB handshake
	// ----------------------------------------
	// Zero wait states: ready is raised in the access phase and errors flag unmapped words.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
		end
	end

	// Read data is fetched in the setup cycle so it is stable in the access phase.
	always_ff @(posedge clk)
	begin
		if (rst)
			prdata <= 32'h00000000;
		else if (apb_rd)
		begin
			unique case (paddr)
				SWB_OFS_INSTR: prdata <= {16'h0000, instr_r};
				SWB_OFS_ACC: prdata <= {24'h000000, acc_r};
				SWB_OFS_STATUS: prdata <= {27'h0000000, flags_r};
				SWB_OFS_BANK: prdata <= {28'h0000000, bank_pointer_r};
				SWB_OFS_INDEX: prdata <= {20'h00000, index_r};
				SWB_OFS_CTRL: prdata <= {30'h00000000, busy, ext_set_r};
				SWB_OFS_FADDR: prdata <= {24'h000000, faddr_r};
				SWB_OFS_FDATA: prdata <= {24'h000000, file_r[faddr_r]};
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// Writes land at the access edge; an instruction write while busy is dropped.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			instr_r <= 16'h0000;
			bank_pointer_r <= 4'h0;
			index_r <= 12'h000;
			ext_set_r <= 1'b0;
			faddr_r <= 8'h00;
			start_r <= 1'b0;
		end
		else
		begin
			start_r <= 1'b0;
			if (apb_wr && pready)
			begin
				unique case (paddr)
					SWB_OFS_INSTR:
					begin
						if (!busy && !start_r)
						begin
							instr_r <= pwdata[15:0];
							start_r <= 1'b1;
						end
					end
					SWB_OFS_BANK: bank_pointer_r <= pwdata[3:0];
					SWB_OFS_INDEX: index_r <= pwdata[11:0];
					SWB_OFS_CTRL: ext_set_r <= pwdata[0];
					SWB_OFS_FADDR: faddr_r <= pwdata[7:0];
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Instruction cycle sequencer
	// ----------------------------------------
	// Four phases: decode, read file, process, write destination.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			phase_r <= SWB_DECODE;
			busy <= 1'b0;
			illegal_op <= 1'b0;
			eff_addr_r <= 8'h00;
			full_addr_r <= 12'h000;
			fval_r <= 8'h00;
			res_r <= '0;
		end
		else if (start_r)
		begin
			busy <= (instr_r[SWB_OP_HI:SWB_OP_LO] == SWB_OPCODE); // [RULE7]
			illegal_op <= (instr_r[SWB_OP_HI:SWB_OP_LO] != SWB_OPCODE);
			full_addr_r <= resolve(instr_r, bank_pointer_r, index_r, ext_set_r);
			// Busy then spans decode, read, process and write, four cycles in all.
			phase_r <= SWB_DECODE;
		end
		else if (busy)
		begin
			unique case (phase_r)
				SWB_DECODE: phase_r <= SWB_READ;
				SWB_READ:
				begin
					// Only the low byte indexes the local file store.
					eff_addr_r <= full_addr_r[7:0];
					fval_r <= file_r[full_addr_r[7:0]];
					phase_r <= SWB_PROCESS;
				end
				SWB_PROCESS:
				begin
					res_r <= res;
					phase_r <= SWB_WRITE;
				end
				SWB_WRITE:
				begin
					phase_r <= SWB_DECODE;
					busy <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Destination write and flags
	// ----------------------------------------
	// During an instruction the accumulator and flags update only in the write phase; software writes them while idle.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			acc_r <= SWB_ACC_RST;
			flags_r <= SWB_FLAGS_RST;
		end
		else if (busy && phase_r == SWB_WRITE)
		begin
			flags_r <= res_r.flags; // [RULE7]
			if (!instr_r[SWB_D_BIT])
				acc_r <= res_r.value; // [RULE2]
		end
		else if (apb_wr && pready && !busy)
		begin
			if (paddr == SWB_OFS_ACC)
				acc_r <= pwdata[7:0];
			if (paddr == SWB_OFS_STATUS)
				flags_r <= pwdata[4:0];
		end
	end

	// File store: written by the instruction or by software through the data window.
	always_ff @(posedge clk)
	begin
		if (busy && phase_r == SWB_WRITE && instr_r[SWB_D_BIT])
			file_r[eff_addr_r] <= res_r.value; // [RULE3]
		else if (apb_wr && pready && !busy && paddr == SWB_OFS_FDATA)
			file_r[faddr_r] <= pwdata[7:0];
	end

endmodule

/* tb/swb_exec_asserts.sv */
// Purpose: Port checks for the subtract-with-borrow execution block.
// Assumes: Zero wait state APB slave, synchronous active high reset.
// Notes: Bound to every swb_exec instance.
`timescale 1ns/1ns
module swb_exec_chk
	import swb_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Status
	input wire logic busy,
	input wire logic illegal_op
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	// A taken write to the instruction register while idle.
	sequence instr_take;
		pready && pwrite && paddr == SWB_OFS_INSTR && !busy;
	endsequence
	// One instruction cycle is four phases, then idle again.
	sequence four_phases;
		busy [*4] ##1 !busy;
	endsequence

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	chk_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup.");
	chk_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready held too long.");
	chk_ready_idle_bus: assert property (!psel |=> !pready)
		else $error("pready without a transfer.");
	chk_error_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr outside access.");
	chk_error_unmapped: assert property (psel && !penable && (paddr[1:0] != 2'h0
		|| paddr > SWB_OFS_FDATA) |=> pslverr)
		else $error("pslverr missing for unmapped address.");
	chk_start_busy: assert property (
		instr_take and pwdata[15:10] == SWB_OPCODE |-> ##[1:3] busy)
		else $error("instruction did not start.");
	chk_cycle_length: assert property ($rose(busy) |-> four_phases)
		else $error("instruction cycle length wrong.");
	chk_illegal_flag: assert property (
		instr_take and pwdata[15:10] != SWB_OPCODE |-> ##[1:3] illegal_op)
		else $error("illegal opcode not flagged.");
	chk_rdata_held: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("prdata changed without a read.");
endmodule

bind swb_exec swb_exec_chk i_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .busy(busy), .illegal_op(illegal_op));

/* tb/testbench.sv */
// Purpose: Self-checking bench for the subtract-with-borrow execution block.
// Assumes: Zero wait state APB, status word {N, OV, Z, DC, C}.
// Notes: Each case presets file, accumulator and carry, then runs one instruction.
`timescale 1ns/1ns
module testbench
	import swb_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic busy;
	logic illegal_op;
	logic [31:0] rdv;
	logic errv;
	int num_errors = 0;
	int cmp_count = 0;

	// The clock toggles every half period of 5 ns.
	always #5 clk = ~clk;

	swb_exec i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.busy(busy), .illegal_op(illegal_op));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	// Answer is sampled at the edge where pready is seen; the wait is bounded.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge, so the next call never drives psel twice in one step.
		@(posedge clk);
	endtask

	task automatic exam(input logic [15:0] ins, input logic [7:0] loc, fv, w,
		input logic [4:0] st, input logic [7:0] res, input logic [4:0] est);
		int n;
		n = 0;
		xfer(1'b1, SWB_OFS_FADDR, {8'h0, loc});
		xfer(1'b1, SWB_OFS_FDATA, {8'h0, fv});
		xfer(1'b1, SWB_OFS_ACC, {8'h0, w});
		xfer(1'b1, SWB_OFS_STATUS, {11'h0, st});
		xfer(1'b1, SWB_OFS_INSTR, ins);
		while (busy !== 1'b1 && n < 8)
		begin
			@(posedge clk);
			n++;
		end
		while (busy !== 1'b0 && n < 16)
		begin
			@(posedge clk);
			n++;
		end
		xfer(1'b0, SWB_OFS_FDATA, 16'h0);
		check("file", rdv, {24'h0, ins[9] ? res : fv});
		xfer(1'b0, SWB_OFS_ACC, 16'h0);
		check("acc", rdv, {24'h0, ins[9] ? w : res});
		xfer(1'b0, SWB_OFS_STATUS, 16'h0);
		check("status", rdv, {27'h0, est});
	endtask

	task automatic complete_run();
		$display("errors %0d, comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		xfer(1'b0, SWB_OFS_ACC, 16'h0);
		check("acc reset", rdv, 32'h0);
		exam(16'h5A25, 8'h25, 8'h19, 8'h0D, 5'h01, 8'h0C, 5'h01);
		exam(16'h5830, 8'h30, 8'h1B, 8'h1A, 5'h00, 8'h00, 5'h07);
		exam(16'h5A61, 8'h61, 8'h03, 8'h0E, 5'h01, 8'hF5, 5'h10);
		exam(16'h5A70, 8'h70, 8'h80, 8'h01, 5'h01, 8'h7F, 5'h09);
		xfer(1'b1, SWB_OFS_CTRL, 16'h0001);
		xfer(1'b1, SWB_OFS_INDEX, 16'h0040);
		xfer(1'b1, SWB_OFS_BANK, 16'h0003);
		exam(16'h5A05, 8'h45, 8'h22, 8'h11, 5'h01, 8'h11, 5'h03);
		exam(16'h5A60, 8'h60, 8'h05, 8'h05, 5'h00, 8'hFF, 5'h10);
		exam(16'h5B44, 8'h44, 8'h50, 8'h10, 5'h01, 8'h40, 5'h03);
		xfer(1'b0, 8'h20, 16'h0);
		check("pslverr", {31'h0, errv}, 32'h1);
		xfer(1'b1, SWB_OFS_INSTR, 16'h5E00);
		repeat (3) @(posedge clk);
		check("illegal_op", {31'h0, illegal_op}, 32'h1);
		complete_run();
	end

	// Watchdog, well above the roughly 230 cycles the cases take.
	initial
	begin
		repeat (5000) @(posedge clk);
		num_errors++;
		complete_run();
	end
endmodule
